// *** include/acc_consts.vh ***
/*
 Constants for the core calibration controller: register offsets, field positions,
 reset values and timing counts. Assumes inclusion by bare name from src files.
*/
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

`define ACC_ADDR_W 8
`define ACC_OFS_CTRL 8'h00
`define ACC_OFS_STATUS 8'h04
`define ACC_OFS_TRIM_SEL 8'h08
`define ACC_OFS_TRIM_DATA 8'h0c
`define ACC_OFS_CAL_LEN 8'h10
`define ACC_OFS_SWAP_PERIOD 8'h14
`define ACC_OFS_SRC_DLY 8'h9a
`define ACC_OFS_MUX_DLY 8'h9b

`define ACC_CTRL_SOFT_TRIG 0
`define ACC_CTRL_TRIG_SEL 1
`define ACC_CTRL_BG_EN 2
`define ACC_CTRL_RESET 3'h0

`define ACC_ST_FG_BUSY 0
`define ACC_ST_FG_DONE 1
`define ACC_ST_BG_ACTIVE 2
`define ACC_ST_SPARE_LSB 4
`define ACC_ST_MAP_LSB 8

`define ACC_SRC_DLY_RESET 8'h00
`define ACC_MUX_DLY_RESET 8'h00
`define ACC_CAL_LEN_RESET 16'h0100
`define ACC_SWAP_PERIOD_RESET 16'h0400

`define ACC_NUM_CORES 6
`define ACC_NUM_TRIM 18
`define ACC_TRIM_W 8
`define ACC_TRIM_RESET 8'h80
`define ACC_MID_CODE 9'h000
`define ACC_SAMPLE_W 9

`endif

// *** src/acc_trim_bank.v ***
/*
 Trim value store: offset, gain and termination trims for each core, loaded with
 factory defaults at reset, readable and writable by software.
 Assumes a single clock and synchronous reset.
*/
module acc_trim_bank (
    input wire ref_clk_in,
    input wire reset_in,
    input wire [4:0] sel_in,
    input wire wr_in,
    input wire [7:0] wdata_in,
    output wire [7:0] rdata_out
);
`include "acc_consts.vh"

reg [7:0] trim_reg [0:`ACC_NUM_TRIM-1];

genvar gi;
generate
    for (gi = 0; gi < `ACC_NUM_TRIM; gi = gi + 1) begin : g_trim
        always @(posedge ref_clk_in) begin
            if (reset_in) begin
                trim_reg[gi] <= `ACC_TRIM_RESET;
            end else if (wr_in && sel_in == gi) begin
                trim_reg[gi] <= wdata_in;
            end
        end
    end
endgenerate

assign rdata_out = (sel_in < `ACC_NUM_TRIM) ? trim_reg[sel_in] : 8'h00;

endmodule // acc_trim_bank

// *** src/acc_sync2.v ***
/*
 Two-flop synchroniser for one asynchronous level.
 Assumes the destination clock is ref_clk_in.
*/
module acc_sync2 (
    input wire ref_clk_in,
    input wire reset_in,
    input wire async_in,
    output wire sync_out
);
reg meta_reg;
reg sync_reg;

always @(posedge ref_clk_in) begin
    if (reset_in) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
    end else begin
        meta_reg <= async_in;
        sync_reg <= meta_reg;
    end
end

assign sync_out = sync_reg;

endmodule // acc_sync2

// *** src/acc_cal_ctrl.v ***
/*
 Calibration sequencer for six converter cores: foreground calibration with
 mid-code output, background rotation of spare cores, trim store and an Avalon-MM
 register slave. Assumes samples of all six cores arrive on ref_clk_in and the
 trigger pin is asynchronous.
// Behaviour
// - Foreground calibration takes all cores offline and outputs mid-code zero.
// - Six cores; foreground maps inputs A,B,C,D to cores 0,1,4,5.
// - Quad background: spare 2 covers cores 0,1; spare 3 covers 4,5.
// - Dual and single background: spare 2 covers core 0 only.
// - Calibration uses internal reference, not the analog input.
// - Factory trims for offset, gain, termination are readable and writable.
// - Foreground calibration runs automatically after every reset.
// - Trigger from pin or software bit, chosen by source select.
// - Background calibrates one core at a time; outputs never interrupted.
// - Calibrated core replaces next active core; rotation repeats forever.
*/
// Local design decision: register access over Avalon-MM.
module acc_cal_ctrl (
    input wire ref_clk_in,
    input wire reset_in,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire [1:0] variant_in,
    input wire calibration_trigger_pin_in,
    input wire [53:0] core_sample_in,
    output wire [5:0] core_cal_out,
    output wire [5:0] core_online_out,
    output wire [5:0] cal_ref_sel_out,
    output wire [35:0] channel_data_out,
    output wire fg_busy_out
);
`include "acc_consts.vh"

localparam ST_FG_CAL = 2'h0;
localparam ST_IDLE = 2'h1;
localparam ST_BG_RUN = 2'h2;
localparam ST_BG_CAL = 2'h3;

// Variant codes: 0 quad, 1 dual, 2 single
localparam VAR_QUAD = 2'h0;

reg [1:0] state_reg;
reg [1:0] state_next;
reg [15:0] cnt_reg;
reg [15:0] cnt_next;
reg [2:0] ctrl_reg;
reg [7:0] src_dly_reg;
reg [7:0] mux_dly_reg;
reg [15:0] cal_len_reg;
reg [15:0] swap_period_reg;
reg [4:0] trim_sel_reg;
reg fg_done_reg;
reg trig_prev_reg;
reg ack_reg;
reg [31:0] rdata_reg;
// Background rotation: slot index and per-slot core assignment
reg [1:0] slot_reg;
reg [1:0] slot_next;
reg [2:0] map_a_reg;
reg [2:0] map_b_reg;
reg [2:0] map_c_reg;
reg [2:0] map_d_reg;
reg [2:0] spare0_reg;
reg [2:0] spare1_reg;
reg [35:0] data_reg;

wire pin_sync;
wire trig_src;
wire trig_rise;
wire [7:0] trim_rdata;
wire bus_req;
wire wr_hit;
wire [5:0] cal_mask;
wire quad;

acc_sync2 u_sync (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .async_in(calibration_trigger_pin_in),
    .sync_out(pin_sync)
);

acc_trim_bank u_trim (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .sel_in(trim_sel_reg),
    .wr_in(wr_hit && avs_address == `ACC_OFS_TRIM_DATA),
    .wdata_in(avs_writedata[7:0]),
    .rdata_out(trim_rdata)
);

assign quad = (variant_in == VAR_QUAD);
// Trigger source select: 1 picks the pin, 0 the software bit
assign trig_src = ctrl_reg[`ACC_CTRL_TRIG_SEL] ? pin_sync
                                               : ctrl_reg[`ACC_CTRL_SOFT_TRIG];
assign trig_rise = trig_src && !trig_prev_reg;

// Bus: one wait cycle per access, then acknowledge
assign bus_req = avs_read || avs_write;
assign avs_waitrequest = bus_req && !ack_reg;
assign wr_hit = avs_write && !ack_reg;
assign avs_readdata = rdata_reg;

always @(posedge ref_clk_in) begin
    if (reset_in) begin
        ack_reg <= 1'b0;
    end else begin
        ack_reg <= bus_req && !ack_reg;
    end
end

always @(posedge ref_clk_in) begin
    if (reset_in) begin
        ctrl_reg <= `ACC_CTRL_RESET;
        src_dly_reg <= `ACC_SRC_DLY_RESET;
        mux_dly_reg <= `ACC_MUX_DLY_RESET;
        cal_len_reg <= `ACC_CAL_LEN_RESET;
        swap_period_reg <= `ACC_SWAP_PERIOD_RESET;
        trim_sel_reg <= 5'h00;
    end else if (wr_hit) begin
        if (avs_address == `ACC_OFS_CTRL) begin
            ctrl_reg <= avs_writedata[2:0];
        end else if (avs_address == `ACC_OFS_TRIM_SEL) begin
            trim_sel_reg <= avs_writedata[4:0];
        end else if (avs_address == `ACC_OFS_CAL_LEN) begin
            cal_len_reg <= avs_writedata[15:0];
        end else if (avs_address == `ACC_OFS_SWAP_PERIOD) begin
            swap_period_reg <= avs_writedata[15:0];
        end else if (avs_address == `ACC_OFS_SRC_DLY) begin
            src_dly_reg <= avs_writedata[7:0];
        end else if (avs_address == `ACC_OFS_MUX_DLY) begin
            mux_dly_reg <= avs_writedata[7:0];
        end
    end
end

always @(posedge ref_clk_in) begin
    if (reset_in) begin
        rdata_reg <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
        if (avs_address == `ACC_OFS_CTRL) begin
            rdata_reg <= {29'h0000_0000, ctrl_reg};
        end else if (avs_address == `ACC_OFS_STATUS) begin
            rdata_reg <= {12'h000, map_d_reg, map_c_reg, map_b_reg, map_a_reg,
                          1'b0, spare1_reg, 1'b0, state_reg == ST_BG_CAL,
                          fg_done_reg, state_reg == ST_FG_CAL};
        end else if (avs_address == `ACC_OFS_TRIM_SEL) begin
            rdata_reg <= {27'h0000000, trim_sel_reg};
        end else if (avs_address == `ACC_OFS_TRIM_DATA) begin
            rdata_reg <= {24'h000000, trim_rdata};
        end else if (avs_address == `ACC_OFS_CAL_LEN) begin
            rdata_reg <= {16'h0000, cal_len_reg};
        end else if (avs_address == `ACC_OFS_SWAP_PERIOD) begin
            rdata_reg <= {16'h0000, swap_period_reg};
        end else if (avs_address == `ACC_OFS_SRC_DLY) begin
            rdata_reg <= {24'h000000, src_dly_reg};
        end else if (avs_address == `ACC_OFS_MUX_DLY) begin
            rdata_reg <= {24'h000000, mux_dly_reg};
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end
end

// Sequencer
always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    slot_next = slot_reg;
    case (state_reg)
        ST_FG_CAL: begin
            if (cnt_reg >= cal_len_reg) begin
                state_next = ST_IDLE;
                cnt_next = 16'h0000;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
        ST_IDLE: begin
            if (trig_rise && !ctrl_reg[`ACC_CTRL_BG_EN]) begin
                state_next = ST_FG_CAL;
                cnt_next = 16'h0000;
            end else if (ctrl_reg[`ACC_CTRL_BG_EN] && trig_src) begin
                state_next = ST_BG_CAL;
                cnt_next = 16'h0000;
            end
        end
        ST_BG_CAL: begin
            if (!ctrl_reg[`ACC_CTRL_BG_EN]) begin
                state_next = ST_IDLE;
            end else if (cnt_reg >= cal_len_reg) begin
                state_next = ST_BG_RUN;
                cnt_next = 16'h0000;
                slot_next = slot_reg + 2'h1;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
        default: begin
            if (!ctrl_reg[`ACC_CTRL_BG_EN]) begin
                state_next = ST_IDLE;
            end else if (cnt_reg >= swap_period_reg) begin
                state_next = ST_BG_CAL;
                cnt_next = 16'h0000;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    endcase
end

always @(posedge ref_clk_in) begin
    if (reset_in) begin
        state_reg <= ST_FG_CAL;
        cnt_reg <= 16'h0000;
        slot_reg <= 2'h0;
        fg_done_reg <= 1'b0;
        trig_prev_reg <= 1'b0;
    end else begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
        slot_reg <= slot_next;
        trig_prev_reg <= trig_src;
        if (state_next == ST_FG_CAL) begin
            fg_done_reg <= 1'b0;
        end else if (state_reg == ST_FG_CAL) begin
            fg_done_reg <= 1'b1;
        end
    end
end

// Core map: finished spare takes over the next active core of its pair
always @(posedge ref_clk_in) begin
    if (reset_in || state_reg == ST_FG_CAL || state_reg == ST_IDLE) begin
        map_a_reg <= 3'h0;
        map_b_reg <= 3'h1;
        map_c_reg <= 3'h4;
        map_d_reg <= 3'h5;
        spare0_reg <= 3'h2;
        spare1_reg <= 3'h3;
    end else if (state_reg == ST_BG_CAL && state_next == ST_BG_RUN) begin
        if (!quad || !slot_reg[0]) begin
            if (!quad || map_a_reg != 3'h0 || slot_reg[1]) begin
                map_a_reg <= spare0_reg;
                spare0_reg <= map_a_reg;
            end else begin
                map_b_reg <= spare0_reg;
                spare0_reg <= map_b_reg;
            end
        end else begin
            if (slot_reg[1]) begin
                map_c_reg <= spare1_reg;
                spare1_reg <= map_c_reg;
            end else begin
                map_d_reg <= spare1_reg;
                spare1_reg <= map_d_reg;
            end
        end
    end
end

// At most one core calibrates at a time in background; none between swaps
assign cal_mask = (state_reg == ST_FG_CAL) ? 6'h3f :
                  (state_reg != ST_BG_CAL) ? 6'h00 :
                  (quad && slot_reg[0]) ? (6'h01 << spare1_reg) :
                  (6'h01 << spare0_reg);
assign core_cal_out = cal_mask;
assign cal_ref_sel_out = cal_mask;
assign core_online_out = (state_reg == ST_FG_CAL) ? 6'h00 : ~cal_mask;
assign fg_busy_out = (state_reg == ST_FG_CAL);

// Output register: the mux select changes only between whole samples
always @(posedge ref_clk_in) begin
    if (reset_in) begin
        data_reg <= 36'h0;
    end else if (state_reg == ST_FG_CAL) begin
        data_reg <= {4{`ACC_MID_CODE}};
    end else begin
        data_reg <= {core_sample_in[map_d_reg*9 +: 9], core_sample_in[map_c_reg*9 +: 9],
                     core_sample_in[map_b_reg*9 +: 9],
                     core_sample_in[map_a_reg*9 +: 9]};
    end
end

assign channel_data_out = data_reg;

endmodule // acc_cal_ctrl

// *** testbench/acc_cal_ctrl_sva.sv ***
/* Checker for acc_cal_ctrl: calibration and bus timing properties.
   Assumes binding to the top module; one clock, sync reset. */
module acc_cal_ctrl_chk (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [5:0] core_cal_out,
    input wire logic [5:0] core_online_out,
    input wire logic [5:0] cal_ref_sel_out,
    input wire logic [35:0] channel_data_out,
    input wire logic fg_busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    a_fg_mid_code: assert property ($past(fg_busy_out) |-> channel_data_out == 36'h0)
        else $error("output not mid-code in calibration");
    a_fg_all_offline: assert property (fg_busy_out |-> core_online_out == 6'h00
        && core_cal_out == 6'h3f) else $error("cores online in calibration");
    a_ref_follows_cal: assert property (cal_ref_sel_out == core_cal_out)
        else $error("reference select differs from calibrated cores");
    a_bg_one_core: assert property (!fg_busy_out |-> $countones(core_cal_out) <= 1)
        else $error("more than one core calibrating");
    a_cal_not_online: assert property ((core_cal_out & core_online_out) == 6'h00)
        else $error("core both calibrating and online");
    a_power_up_cal: assert property ($fell(reset_in) |-> fg_busy_out [*8])
        else $error("no calibration after reset");
    a_bus_one_wait: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("wait state count wrong");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'h20
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
endmodule // acc_cal_ctrl_chk

bind acc_cal_ctrl acc_cal_ctrl_chk acc_cal_ctrl_chk_inst (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_cal_out(core_cal_out), .core_online_out(core_online_out),
    .cal_ref_sel_out(cal_ref_sel_out), .channel_data_out(channel_data_out),
    .fg_busy_out(fg_busy_out));

// *** testbench/acc_ctl_partner.sv ***
/* Far-side model: fixed per-core samples and a trigger pin pulse.
   Assumes fire_in is a one-cycle request from the bench. */
module acc_ctl_partner (
    input wire logic ref_clk_in,
    input wire logic fire_in,
    output logic [53:0] core_sample_out,
    output logic trig_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold = 0;
    always_comb begin
        for (int k = 0; k < 6; k++)
            core_sample_out[9*k +: 9] = 9'(17 * (k + 1));
    end
    always @(posedge ref_clk_in) begin
        if (fire_in)
            hold <= 4;
        else if (hold > 0)
            hold <= hold - 1;
    end
    assign trig_pin_out = (hold > 0);
endmodule // acc_ctl_partner

// *** testbench/acc_cal_ctrl_tb_top.sv ***
/* Testbench for acc_cal_ctrl: power-up, registers, triggers, background rotation.
   Assumes the design and partner model are compiled first. */
module acc_cal_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, rd = 0, wr = 0, fire = 0, wait_rq, pin, busy;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0, rdata;
    logic [1:0] variant = 2'h0;
    logic [53:0] samp;
    logic [5:0] cal, onl, refs;
    logic [35:0] data;
    int err_count = 0, check_count = 0, cyc = 0;
    always #2 clk = ~clk;
    acc_ctl_partner acc_ctl_partner_inst (.ref_clk_in(clk), .fire_in(fire),
        .core_sample_out(samp), .trig_pin_out(pin));
    acc_cal_ctrl acc_cal_ctrl_inst (.ref_clk_in(clk), .reset_in(rst), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
        .avs_waitrequest(wait_rq), .variant_in(variant), .calibration_trigger_pin_in(pin),
        .core_sample_in(samp), .core_cal_out(cal), .core_online_out(onl),
        .cal_ref_sel_out(refs), .channel_data_out(data), .fg_busy_out(busy));
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wait_rq !== 1'b0 && n < 50);
        if (n == 50)
            err_count++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic do_reset(input logic [1:0] v);
        @(posedge clk);
        rst <= 1'b1;
        variant <= v;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_done;
        logic [31:0] q;
        int n;
        q = 0;
        n = 0;
        while (q[1] !== 1'b1 && n < 200) begin
            bus(0, 8'h04, 0, q);
            n++;
        end
        chk(q[1], 1);
    endtask
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 12) begin
            @(posedge clk);
            n++;
        end
        chk(busy, lvl);
    endtask
    task automatic t_fg;
        logic [31:0] q;
        chk(busy, 1);
        chk(data, 0);
        chk(onl, 0);
        wait_done();
        bus(0, 8'h04, 0, q);
        chk(q[19:8], 12'o5410);
        repeat (2) @(posedge clk);
        chk(data, {9'h066, 9'h055, 9'h022, 9'h011});
        $display("test fg done");
    endtask
    task automatic t_regs;
        logic [31:0] q;
        logic [7:0] ofs[6] = '{8'h0c, 8'h10, 8'h14, 8'h9a, 8'h9b, 8'h20};
        logic [15:0] rv[2][6] = '{'{16'h80, 16'h100, 16'h400, 16'h0, 16'h0, 16'h0},
                                  '{16'h3c, 16'h100, 16'h400, 16'h1f, 16'h1e, 16'h0}};
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 6; i++) begin
                bus(0, ofs[i], 0, q);
                chk(q, rv[p][i]);
            end
            if (p == 0) begin
                bus(1, 8'h9a, 32'h1f, q);
                bus(1, 8'h9b, 32'h1e, q);
                bus(1, 8'h08, 32'h5, q);
                bus(1, 8'h0c, 32'h3c, q);
                bus(1, 8'h20, 32'h7, q);
            end
        end
        $display("test regs done");
    endtask
    task automatic t_trig;
        logic [31:0] q;
        bus(1, 8'h10, 32'h4, q);
        bus(1, 8'h00, 32'h0, q);
        bus(1, 8'h00, 32'h1, q);
        wait_busy(1);
        wait_busy(0);
        for (int s = 0; s < 2; s++) begin
            bus(1, 8'h00, s ? 32'h0 : 32'h2, q);
            @(posedge clk);
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            if (s == 0) begin
                wait_busy(1);
                wait_busy(0);
                bus(1, 8'h00, 32'h3, q);
            end
            repeat (12) @(posedge clk);
            chk(busy, 0);
        end
        $display("test trig done");
    endtask
    task automatic t_bg(input logic [1:0] v, input logic [5:0] e);
        logic [31:0] q;
        logic [5:0] seen;
        int bad;
        seen = 0;
        bad = 0;
        do_reset(v);
        wait_done();
        bus(1, 8'h10, 32'h4, q);
        bus(1, 8'h14, 32'h4, q);
        bus(1, 8'h00, 32'h5, q);
        repeat (300) begin
            @(posedge clk);
            seen |= cal;
            if (busy !== 1'b0 || !(data[8:0] inside {9'h011, 9'h022, 9'h033}))
                bad++;
        end
        chk(bad, 0);
        chk(seen, e);
        $display("test bg variant %0d done", v);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        do_reset(2'h0);
        t_fg();
        t_regs();
        t_trig();
        t_bg(2'h0, 6'h3f);
        t_bg(2'h1, 6'h05);
        t_bg(2'h2, 6'h05);
        tally_and_finish();
    end
endmodule // acc_cal_ctrl_tb_top
